// [wfpfc_bus_node.sv]
// Purpose: Bus node sending dominant pulses to the receive pins
// Assumes: Recessive idle is high on both pins
// Notes:   Raw-only pulses stand for ones the analog filter ate
`timescale 1ns/1ps
module wfpfc_bus_node (
    input  wire logic clk,
    output logic      rx_raw_pin,
    output logic      rx_analog_pin
);
    initial begin
        rx_raw_pin    = 1'b1;
        rx_analog_pin = 1'b1;
    end
    task automatic send(input int len, input logic both);
        @(posedge clk);
        rx_raw_pin    <= 1'b0;
        rx_analog_pin <= !both;
        repeat (len) @(posedge clk);
        rx_raw_pin    <= 1'b1;
        rx_analog_pin <= 1'b1;
    endtask : send
endmodule : wfpfc_bus_node

// [wfpfc_dom_filter.sv]
// Purpose: Digital dominant-pulse filter for the received bus level
// Assumes: Input is already synchronised; low level is dominant
// Notes:   Recessive passes at once; dominant only after limit cycles
`timescale 1ns/1ps
module wfpfc_dom_filter
    import wfpfc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  rx_in,
    input  wire logic [FILT_CNT_W-1:0] limit,
    output logic                       rx_q
);

    logic [FILT_CNT_W-1:0] cnt_q;
    logic [FILT_CNT_W-1:0] cnt_d;
    logic                  rx_d;
    wire                   reached = (cnt_q + 1'b1) >= limit;

    assign cnt_d = rx_in ? '0 : (reached ? cnt_q : cnt_q + 1'b1);
    assign rx_d  = rx_in | (rx_q & ~reached);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            rx_q  <= 1'b1;
        end else if (ce) begin
            cnt_q <= cnt_d;
            rx_q  <= rx_d;
        end
    end

endmodule : wfpfc_dom_filter

// [wfpfc_pkg.sv]
// Purpose: Shared constants for the wake-frame payload and fast-rate config
// Assumes: 50 MHz clock, APB register access, one 8-bit register per word
// Notes:   Register indices are word indices; byte address is index * 4
package wfpfc_pkg;

    localparam int          CLK_PERIOD_NS = 20;
    localparam int          APB_ADDR_W    = 8;
    localparam int          IDX_W         = APB_ADDR_W - 2;
    localparam int          PAYLOAD_BYTES = 8;

    // Register indices
    localparam logic [IDX_W-1:0] REG_BYTE7_IDX = 6'h2C;
    localparam logic [IDX_W-1:0] REG_BYTE6_IDX = 6'h2D;
    localparam logic [IDX_W-1:0] REG_BYTE5_IDX = 6'h2E;
    localparam logic [IDX_W-1:0] REG_BYTE4_IDX = 6'h2F;
    localparam logic [IDX_W-1:0] REG_BYTE3_IDX = 6'h30;
    localparam logic [IDX_W-1:0] REG_BYTE2_IDX = 6'h31;
    localparam logic [IDX_W-1:0] REG_BYTE1_IDX = 6'h32;
    localparam logic [IDX_W-1:0] REG_BYTE0_IDX = 6'h33;
    localparam logic [IDX_W-1:0] REG_CFG_IDX   = 6'h34;

    // Reset values
    localparam logic [7:0] PAYLOAD_RESET = 8'h00;
    localparam logic [5:0] CFG_RESET     = 6'h00;

    // Config register fields
    localparam int CFG_W          = 6;
    localparam int CFG_FD_EN_BIT  = 0;
    localparam int CFG_FILT_LSB   = 1;
    localparam int CFG_FILT_W     = 3;
    localparam int CFG_BYPASS_BIT = 4;
    localparam int CFG_SUPP_BIT   = 5;

    // Dominant filter times
    localparam int         FILT_STEP_NS = 50;
    localparam int         FILT_MAX_NS  = 387;
    localparam logic [2:0] FILT_MAX_CODE = 3'h7;
    localparam int         FILT_CNT_W   = 5;

    // Frame length
    localparam logic [3:0] DLC_MAX_BYTES = 4'h8;

    // Filter time in cycles, least time rounded up
    function automatic logic [FILT_CNT_W-1:0] wfpfc_filt_cycles(
        input logic [2:0] code
    );
        int ns;
        ns = (code == FILT_MAX_CODE) ? FILT_MAX_NS
                                     : FILT_STEP_NS * (int'(code) + 1);
        return FILT_CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : wfpfc_filt_cycles

    // Payload length from data length code
    function automatic logic [3:0] wfpfc_dlc_len(input logic [3:0] dlc);
        return (dlc > 4'h7) ? DLC_MAX_BYTES : dlc;
    endfunction : wfpfc_dlc_len

endpackage : wfpfc_pkg

// [wfpfc_top.sv]
// Purpose: Wake-frame payload bytes and fast-rate tolerance configuration
// Assumes: APB slave, soft reset and silence timeout from the same clock
// Notes:   Bus receive pins pass a two-stage synchroniser first
// How it works
// - Each payload register holds one 8-bit byte, bit 0 least significant.
// - Payload registers clear to zero on power-on or soft reset.
// - Payload bytes 6 to 0 sit at indices 0x2d up to 0x33.
// - Config bit 0 enables fast-rate tolerant selective wake operation.
// - Bits 3:1 pick filter time 50 to 350 ns, code 7 is 387 ns.
// - Config bit 4 routes the received signal around the analog filter.
// - The dominant filter applies whether or not the analog filter is bypassed.
// - Bit 5 stops the error counter only while tolerance is enabled.
// - Silence timeout expiry clears bit 5 in hardware, visible on readback.
// - Config bits 7 and 6 read zero and ignore writes.
// - Config register clears to zero on power-on or soft reset.
// - Payload byte 7 sits at index 0x2c, just below byte 6.
// - Length codes 0 to 7 give that many bytes, larger give eight.
`timescale 1ns/1ps
module wfpfc_top
    import wfpfc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  soft_reset,
    input  wire logic                  silence_expired,
    input  wire logic [3:0]            dlc_code,
    input  wire logic                  rx_raw_pin,
    input  wire logic                  rx_analog_pin,
    output logic [8*PAYLOAD_BYTES-1:0] payload_bytes,
    output logic [3:0]                 payload_len,
    output logic                       fast_rate_tolerance_enable,
    output logic [CFG_FILT_W-1:0]      dominant_pulse_filter_time,
    output logic                       analog_filter_bypass,
    output logic                       error_counter_suppress,
    output logic                       error_counter_run,
    output logic                       rx_filtered
);

    // Register storage
    logic [7:0]       pay_q [PAYLOAD_BYTES];
    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] cfg_d;

    // APB answer registers
    logic             pready_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;

    // Derived outputs
    logic             err_run_q;
    logic [3:0]       len_q;

    // Receive synchronisers
    logic             raw_s1_q;
    logic             raw_s2_q;
    logic             ana_s1_q;
    logic             ana_s2_q;

    // Address decode
    wire [IDX_W-1:0]  word_idx    = paddr[APB_ADDR_W-1:2];
    wire              aligned     = (paddr[1:0] == 2'b00);
    wire              hit_payload = aligned
                                  && (word_idx >= REG_BYTE7_IDX)
                                  && (word_idx <= REG_BYTE0_IDX);
    wire              hit_cfg     = aligned && (word_idx == REG_CFG_IDX);
    wire              map_ok      = hit_payload | hit_cfg;
    wire [2:0]        byte_sel    = 3'(REG_BYTE0_IDX - word_idx);

    // Phase decode: answer comes one cycle into the access phase
    wire              acc_first   = psel & penable & ~pready_q;
    wire              acc_done    = psel & penable & pready_q;
    wire              wr_fire     = acc_done & pwrite & pstrb[0];
    wire              wr_payload  = wr_fire & hit_payload;
    wire              wr_cfg      = wr_fire & hit_cfg;

    // Read selection
    wire [7:0]        pay_rd      = pay_q[byte_sel];
    wire [31:0]       rd_data     = hit_payload ? {24'h0, pay_rd}
                                  : hit_cfg ? {26'h0, cfg_q}
                                  : 32'h0;

    // Config next value
    wire [CFG_W-1:0]  cfg_wr      = wr_cfg ? pwdata[CFG_W-1:0] : cfg_q;

    always_comb begin
        cfg_d = cfg_wr;
        if (silence_expired) begin
            cfg_d[CFG_SUPP_BIT] = 1'b0;
        end
        if (soft_reset) begin
            cfg_d = CFG_RESET;
        end
    end

    // Field views
    wire              fd_en       = cfg_q[CFG_FD_EN_BIT];
    wire              bypass      = cfg_q[CFG_BYPASS_BIT];
    wire              suppress    = cfg_q[CFG_SUPP_BIT];
    wire [2:0]        filt_code   = cfg_q[CFG_FILT_LSB +: CFG_FILT_W];
    wire              err_run_d   = ~(suppress & fd_en);
    wire              rx_sel      = bypass ? raw_s2_q : ana_s2_q;
    wire [FILT_CNT_W-1:0] filt_lim = wfpfc_filt_cycles(filt_code);

    // Payload bytes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PAYLOAD_BYTES; i++) begin
                pay_q[i] <= PAYLOAD_RESET;
            end
        end else if (ce) begin
            if (soft_reset) begin
                for (int i = 0; i < PAYLOAD_BYTES; i++) begin
                    pay_q[i] <= PAYLOAD_RESET;
                end
            end else if (wr_payload) begin
                pay_q[byte_sel] <= pwdata[7:0];
            end
        end
    end

    // Config register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
        end else if (ce) begin
            cfg_q <= cfg_d;
        end
    end

    // APB answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q  <= acc_first;
            pslverr_q <= acc_first & ~map_ok;
            if (acc_first & ~pwrite) begin
                prdata_q <= rd_data;
            end
        end
    end

    // Derived control outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_run_q <= 1'b1;
            len_q     <= 4'h0;
        end else if (ce) begin
            err_run_q <= err_run_d;
            len_q     <= wfpfc_dlc_len(dlc_code);
        end
    end

    // Pin synchronisers, idle recessive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_s1_q <= 1'b1;
            raw_s2_q <= 1'b1;
            ana_s1_q <= 1'b1;
            ana_s2_q <= 1'b1;
        end else if (ce) begin
            raw_s1_q <= rx_raw_pin;
            raw_s2_q <= raw_s1_q;
            ana_s1_q <= rx_analog_pin;
            ana_s2_q <= ana_s1_q;
        end
    end

    // Dominant filter follows the path selection
    wfpfc_dom_filter u_dom_filter (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .rx_in (rx_sel),
        .limit (filt_lim),
        .rx_q  (rx_filtered)
    );

    // Output mapping
    for (genvar n = 0; n < PAYLOAD_BYTES; n++) begin : g_pay
        assign payload_bytes[8*n +: 8] = pay_q[n];
    end

    assign prdata                     = prdata_q;
    assign pready                     = pready_q;
    assign pslverr                    = pslverr_q;
    assign payload_len                = len_q;
    assign fast_rate_tolerance_enable = fd_en;
    assign dominant_pulse_filter_time = filt_code;
    assign analog_filter_bypass       = bypass;
    assign error_counter_suppress     = suppress;
    assign error_counter_run          = err_run_q;

endmodule : wfpfc_top

// [wfpfc_top_sva.sv]
// Purpose: Port checks for the wake payload config bank
// Assumes: Clock enable held high
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module wfpfc_top_sva
    import wfpfc_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [3:0]   pstrb,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         soft_reset,
    input wire logic         silence_expired,
    input wire logic [3:0]   dlc_code,
    input wire logic [63:0]  payload_bytes,
    input wire logic [3:0]   payload_len,
    input wire logic         fast_rate_tolerance_enable,
    input wire logic [2:0]   dominant_pulse_filter_time,
    input wire logic         analog_filter_bypass,
    input wire logic         error_counter_suppress,
    input wire logic         error_counter_run
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [5:0] cfg_now;
    logic       wr_ok;
    assign cfg_now = {error_counter_suppress, analog_filter_bypass,
                      dominant_pulse_filter_time, fast_rate_tolerance_enable};
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
    sequence apb_access;
        psel && !penable ##1 psel && penable;
    endsequence
    answer_wait_a: assert property (apb_access |=> pready)
        else $error("no answer after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    byte_write_a: assert property (
        wr_ok && paddr == 8'hCC && !soft_reset
        |=> payload_bytes[7:0] == $past(pwdata[7:0]))
        else $error("byte 0 write lost");
    cfg_write_a: assert property (
        wr_ok && paddr == 8'hD0 && !soft_reset && !silence_expired
        |=> cfg_now == $past(pwdata[5:0]))
        else $error("config write lost");
    silence_clear_a: assert property (
        silence_expired |=> !error_counter_suppress)
        else $error("suppress bit survives silence");
    soft_clear_a: assert property (
        soft_reset |=> payload_bytes == 64'h0 && cfg_now == 6'h00)
        else $error("soft reset left contents");
    run_follow_a: assert property ($past(rst_n) |->
        error_counter_run == !($past(error_counter_suppress)
        && $past(fast_rate_tolerance_enable)))
        else $error("error counter run wrong");
    len_decode_a: assert property ($past(rst_n) |->
        payload_len == ($past(dlc_code) > 4'h7 ? 4'h8 : $past(dlc_code)))
        else $error("payload length wrong");
endmodule : wfpfc_top_sva

// [wfpfc_top_tb.sv]
// Purpose: Self-checking bench for the wake payload config bank
// Assumes: Clock enable held high
// Notes:   Table of plain accesses first, odd cases after
`timescale 1ns/1ps
module wfpfc_top_tb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic        soft_reset, silence_expired, seen, rx_raw, rx_ana;
    logic        en, byp, supp, run, rx_filtered;
    logic [2:0]  filt;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb, dlc_code, payload_len;
    logic [63:0] payload_bytes;
    int          errors, num_checks;
    // Address, write byte, read byte
    logic [23:0] rows[9] = '{24'hB08080, 24'hB40101, 24'hB8A5A5,
        24'hBC5A5A, 24'hC0C3C3, 24'hC43C3C, 24'hC89696, 24'hCC6969,
        24'hD0FF3F};
    // Config, both pins, pulse length, low seen
    logic [15:0] fc[17] = '{16'h0014, 16'h0095, 16'h1004, 16'h100D,
        16'h1208, 16'h1E1E, 16'h1E33, 16'h140E, 16'h1411, 16'h1612,
        16'h1615, 16'h181B, 16'h1A1C, 16'h1C22, 16'h1C25, 16'h1E26,
        16'h1E29};
    logic [7:0]  bad[4] = '{8'h00, 8'hB1, 8'hD4, 8'hAC};
    wfpfc_top DUT (.clk, .rst_n, .ce(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .soft_reset,
        .silence_expired, .dlc_code, .rx_raw_pin(rx_raw),
        .rx_analog_pin(rx_ana), .payload_bytes, .payload_len,
        .fast_rate_tolerance_enable(en), .dominant_pulse_filter_time(filt),
        .analog_filter_bypass(byp), .error_counter_suppress(supp),
        .error_counter_run(run), .rx_filtered);
    wfpfc_bus_node bus (.clk, .rx_raw_pin(rx_raw), .rx_analog_pin(rx_ana));
    always #10 clk = ~clk;
    always @(posedge clk) if (rx_filtered === 1'b0) seen <= 1'b1;
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(1'b0, 1'b1);
            conclude();
        end
    endtask : apb
    initial begin
        {clk, rst_n, psel, penable, pwrite, soft_reset} = 6'h00;
        {silence_expired, paddr, pwdata} = 41'h0;
        {pstrb, dlc_code, seen, errors, num_checks} = {4'hF, 5'h0, 64'h0};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({payload_bytes, supp, byp, filt, en, run}, 71'h1);
        $display("done reset");
        foreach (rows[i]) begin
            apb(1'b1, rows[i][23:16], {24'hFFFFFF, rows[i][15:8]});
            apb(1'b0, rows[i][23:16], 32'h0);
            chk({e, r}, {25'h0, rows[i][7:0]});
        end
        chk(payload_bytes, 64'h8001A55AC33C9669);
        chk({supp, byp, filt, en, run}, 7'h7E);
        $display("done table");
        apb(1'b1, 8'hD0, 32'h20);
        repeat (2) @(negedge clk);
        chk(run, 1'b1);
        apb(1'b1, 8'hD0, 32'h21);
        silence_expired <= 1'b1;
        @(posedge clk);
        silence_expired <= 1'b0;
        apb(1'b0, 8'hD0, 32'h0);
        chk({r, run}, {32'h1, 1'b1});
        $display("done control");
        pstrb <= 4'hE;
        apb(1'b1, 8'hCC, 32'h11);
        pstrb <= 4'hF;
        foreach (bad[i]) begin
            apb(1'b1, bad[i], 32'hFF);
            chk(e, 1'b1);
            apb(1'b0, bad[i], 32'h0);
            chk({e, r}, {1'b1, 32'h0});
        end
        chk(payload_bytes, 64'h8001A55AC33C9669);
        $display("done refusals");
        for (int i = 0; i < 16; i++) begin
            dlc_code <= i[3:0];
            repeat (2) @(posedge clk);
            chk(payload_len, i > 7 ? 8 : i);
        end
        $display("done length");
        foreach (fc[i]) begin
            apb(1'b1, 8'hD0, {24'h0, fc[i][15:8]});
            seen = 1'b0;
            bus.send(fc[i][6:1], fc[i][7]);
            repeat (30) @(posedge clk);
            chk(seen, fc[i][0]);
        end
        $display("done filter");
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b0, rows[i][23:16], 32'h0);
            chk(r, 32'h0);
        end
        $display("done soft reset");
        conclude();
    end
endmodule : wfpfc_top_tb
bind wfpfc_top wfpfc_top_sva sva_i (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .soft_reset,
    .silence_expired, .dlc_code, .payload_bytes, .payload_len,
    .fast_rate_tolerance_enable, .dominant_pulse_filter_time,
    .analog_filter_bypass, .error_counter_suppress, .error_counter_run);
